/* File: hw/pmc_top.sv */
// Operating-mode controller: clock source and divider, halt modes, wake-up and power flags.
// Assumes halt and clear-watchdog arrive as one-cycle pulses from the core and that the
// sub clock, port A and interrupt inputs are synchronous to ref_clk.
//
// Contract
// - Select code 111 switches system clock to sub clock, SLOW mode.
// - Codes 000 to 110 pick fast clock divided by 1 up to 64.
// - Halt picks SLEEP or IDLE only from the two keep-alive bits.
// - Switch into SLOW waits for the low-speed oscillator to be stable.
// - Fast oscillator restart after SLOW is reported by its stable flag.
// - Halt with both keep bits 0 enters SLEEP, all clocks stop but watchdog.
// - Keep bits fast 0, slow 1 enter IDLE0: fast off, sub clock on.
// - Both keep bits 1 enter IDLE1: both clocks run, program stops.
// - Keep bits fast 1, slow 0 enter IDLE2: fast on, sub clock off.
// - Entering any halt mode leaves memory, registers and ports unchanged.
// - Each halt sets power-down flag and clears watchdog time-out flag; an overflow in the halt cycle sets it instead.
// - Each halt clears the watchdog counter, which keeps counting.
// - Halted device wakes on port A falling edge, interrupt or watchdog overflow.
// - Power-down flag clears only on power-up or clear-watchdog instruction.
// - Watchdog wake sets time-out flag, resets only program counter and stack.
// - Each port A pin has a wake enable; pin wake resumes after halt.
// - Wake by disabled interrupt or full stack resumes after halt, stays pending.
// - Wake by enabled interrupt with stack room vectors at once.
// - Interrupt already requested at halt cannot wake the device.
// - Enabling fast oscillator clears its stable flag until it settles.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps

module pmc_top
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core instructions and answers
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  output logic cpu_run,
  output logic resume_pulse,
  output logic vector_pulse,
  output logic pc_sp_reset,
  // Interrupt controller
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  // Port A pins
  input wire logic [7:0] porta_in,
  // Watchdog
  input wire logic wdt_overflow,
  output logic wdt_clear,
  // Oscillators and clocks
  input wire logic ls_osc_stable,
  input wire logic ls_tick,
  output logic hs_osc_on,
  output logic sub_clk_on,
  output logic sys_tick,
  // State
  output pmc_pkg::pmc_mode_type mode,
  output logic power_down_flag,
  output logic wdt_timeout_flag
);
  import pmc_pkg::*;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [2:0] sys_clk_select_q;
  logic hs_osc_halt_keep_q, ls_osc_halt_keep_q;
  logic hs_osc_enable_q;
  logic [7:0] porta_wake_enable_q;
  logic [7:0] rdata_q, rdata_d;

  wire wr_sysclk = reg_wr && reg_addr == ADDR_SYSCLK_CTRL;
  wire wr_hsctrl = reg_wr && reg_addr == ADDR_HS_OSC_CTRL;
  wire wr_wake = reg_wr && reg_addr == ADDR_WAKE_EN;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sys_clk_select_q <= SEL_RST;
      hs_osc_halt_keep_q <= 1'b0;
      ls_osc_halt_keep_q <= 1'b0;
      hs_osc_enable_q <= HS_EN_RST;
      porta_wake_enable_q <= WAKE_EN_RST;
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
      if (wr_sysclk) begin
        sys_clk_select_q <= reg_wdata[SEL_MSB:SEL_LSB];
        hs_osc_halt_keep_q <= reg_wdata[HS_KEEP_BIT];
        ls_osc_halt_keep_q <= reg_wdata[LS_KEEP_BIT];
      end
      if (wr_hsctrl) hs_osc_enable_q <= reg_wdata[HS_EN_BIT];
      if (wr_wake) porta_wake_enable_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  pmc_state_type st_q, st_d;
  pmc_mode_type mode_q, mode_d;
  logic [7:0] irq_armed_q, porta_prev_q;
  logic wake_wdt_q, wake_irq_q;
  logic [7:0] wake_irq_bits_q;
  logic cpu_run_q, resume_q, vector_q, pc_sp_reset_q;
  logic slow_active, hs_stable_q;

  wire halt_go = st_q == PMC_RUN && halt_exec;
  // Falling edge on an enabled pin
  wire [7:0] pa_fall = porta_prev_q & ~porta_in & porta_wake_enable_q;
  // Requests already pending at halt are not armed
  wire [7:0] irq_wake = irq_req & irq_armed_q;
  wire any_wake = (|pa_fall) || (|irq_wake) || wdt_overflow;
  wire src_ok = slow_active ? ls_osc_stable : hs_stable_q;
  wire irq_serviceable = (|(wake_irq_bits_q & irq_enable)) && !stack_full;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PMC_RUN: if (halt_exec) st_d = PMC_HALT;
      PMC_HALT: if (any_wake) st_d = PMC_RESTART;
      PMC_RESTART: if (src_ok) st_d = PMC_RUN;
    endcase
  end

  // Mode shown follows the state; halt mode only from the keep bits
  always_comb begin
    mode_d = mode_q;
    if (halt_go) begin
      mode_d = pmc_halt_mode(hs_osc_halt_keep_q, ls_osc_halt_keep_q);
    end else if (st_d != PMC_HALT) begin
      mode_d = slow_active ? PMC_SLOW : PMC_FAST;
    end
  end

  // Only the controller's own state changes on halt; data, registers and
  // port levels held elsewhere are untouched since no reset is issued
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= PMC_RUN;
      mode_q <= PMC_FAST;
      irq_armed_q <= 8'h00;
      wake_wdt_q <= 1'b0;
      wake_irq_q <= 1'b0;
      wake_irq_bits_q <= 8'h00;
      porta_prev_q <= 8'hff;
    end else begin
      st_q <= st_d;
      porta_prev_q <= porta_in;
      mode_q <= mode_d;
      if (halt_go) begin
        irq_armed_q <= ~irq_req;
        wake_wdt_q <= 1'b0;
        wake_irq_q <= 1'b0;
      end
      if (st_q == PMC_HALT && any_wake) begin
        wake_wdt_q <= wdt_overflow;
        wake_irq_q <= |irq_wake;
        wake_irq_bits_q <= irq_wake;
      end
    end
  end

  // ----------------------------------------------------------------
  // Release of the core after wake-up
  // ----------------------------------------------------------------
  wire leave_restart = st_q == PMC_RESTART && src_ok;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_run_q <= 1'b1;
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      pc_sp_reset_q <= 1'b0;
    end else begin
      cpu_run_q <= st_d == PMC_RUN;
      // Watchdog wake wins: only PC and stack pointer are reset
      pc_sp_reset_q <= leave_restart && wake_wdt_q;
      vector_q <= leave_restart && !wake_wdt_q && wake_irq_q && irq_serviceable;
      // Pin wake or unserviceable interrupt resumes after the halt
      resume_q <= leave_restart && !wake_wdt_q && !(wake_irq_q && irq_serviceable);
    end
  end

  // ----------------------------------------------------------------
  // Power-down and time-out flags, watchdog clear
  // ----------------------------------------------------------------
  logic pdf_q, to_q, wdt_clear_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pdf_q <= 1'b0;
      to_q <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else begin
      // Set on halt wins; only the clear instruction drops it
      if (halt_go) begin
        pdf_q <= 1'b1;
      end else if (clr_wdt_exec) begin
        pdf_q <= 1'b0;
      end
      // An overflow in the halt cycle still sets the flag
      if (wdt_overflow) begin
        to_q <= 1'b1;
      end else if (halt_go) begin
        to_q <= 1'b0;
      end
      wdt_clear_q <= halt_go || clr_wdt_exec;
    end
  end

  // ----------------------------------------------------------------
  // Oscillators and stable flag
  // ----------------------------------------------------------------
  logic hs_on_q, hs_on_d, sub_on_q, sub_on_d;
  logic [7:0] hs_cnt_q;

  // Fast oscillator runs when enabled or needed as source; in halt only if kept
  assign hs_on_d = (st_d == PMC_HALT) ? hs_osc_halt_keep_q :
                   (hs_osc_enable_q || sys_clk_select_q != SEL_SLOW || !slow_active);
  assign sub_on_d = (st_d == PMC_HALT) ? ls_osc_halt_keep_q : 1'b1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_on_q <= 1'b0;
      sub_on_q <= 1'b0;
      hs_cnt_q <= 8'h00;
      hs_stable_q <= 1'b0;
    end else begin
      hs_on_q <= hs_on_d;
      sub_on_q <= sub_on_d;
      // Counter restarts from zero each time the oscillator is turned on
      if (!hs_on_q) begin
        hs_cnt_q <= 8'h00;
        hs_stable_q <= 1'b0;
      end else if (hs_cnt_q != 8'(HS_STABLE_CYC)) begin
        hs_cnt_q <= hs_cnt_q + 8'h01;
        hs_stable_q <= 1'b0;
      end else begin
        hs_stable_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider and glitch-free source selection
  // ----------------------------------------------------------------
  logic [5:0] div_cnt_q;
  logic sys_tick_q;

  wire target_slow = sys_clk_select_q == SEL_SLOW;
  wire [5:0] div_mask = pmc_div_mask(sys_clk_select_q);
  wire div_tick = hs_on_q && (div_cnt_q & div_mask) == div_mask;

  pmc_clk_switch u_switch (
    .ref_clk(ref_clk),
    .rst(rst),
    .target_slow(target_slow),
    .hs_tick(hs_on_q),
    .ls_tick(ls_tick),
    .hs_ok(hs_stable_q),
    .ls_ok(ls_osc_stable),
    .slow_active(slow_active)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt_q <= 6'h00;
      sys_tick_q <= 1'b0;
    end else begin
      div_cnt_q <= hs_on_q ? div_cnt_q + 6'h01 : 6'h00;
      // Gated by the next state, so no tick leaks into the first halted cycle
      sys_tick_q <= st_d == PMC_RUN && (slow_active ? (ls_tick && sub_on_q) : div_tick);
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SYSCLK_CTRL: begin
          rdata_d[SEL_MSB:SEL_LSB] = sys_clk_select_q;
          rdata_d[HS_KEEP_BIT] = hs_osc_halt_keep_q;
          rdata_d[LS_KEEP_BIT] = ls_osc_halt_keep_q;
        end
        ADDR_HS_OSC_CTRL: begin
          rdata_d[HS_FLAG_BIT] = hs_stable_q;
          rdata_d[HS_EN_BIT] = hs_osc_enable_q;
        end
        ADDR_WAKE_EN: rdata_d = porta_wake_enable_q;
        ADDR_STATUS: begin
          rdata_d[PDF_BIT] = pdf_q;
          rdata_d[TO_BIT] = to_q;
          rdata_d[SLOW_ACT_BIT] = slow_active;
          rdata_d[MODE_LSB +: 3] = mode_q;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign cpu_run = cpu_run_q;
  assign resume_pulse = resume_q;
  assign vector_pulse = vector_q;
  assign pc_sp_reset = pc_sp_reset_q;
  assign wdt_clear = wdt_clear_q;
  assign hs_osc_on = hs_on_q;
  assign sub_clk_on = sub_on_q;
  assign sys_tick = sys_tick_q;
  assign mode = mode_q;
  assign power_down_flag = pdf_q;
  assign wdt_timeout_flag = to_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_fast_div_one: assert property ((st_d == PMC_RUN && !slow_active
    && sys_clk_select_q == 3'h0 && hs_on_q) |=> sys_tick_q)
    else $error("undivided fast clock missed a tick");
  a_halt_mode_pick: assert property (halt_go
    |=> mode_q == pmc_halt_mode($past(hs_osc_halt_keep_q), $past(ls_osc_halt_keep_q)))
    else $error("halt mode not taken from keep bits");
  a_halt_clocks: assert property ((st_q == PMC_HALT) |-> hs_on_q == hs_osc_halt_keep_q
    && sub_on_q == ls_osc_halt_keep_q && !cpu_run_q && !sys_tick_q)
    else $error("clock state wrong while halted");
  a_halt_flags: assert property ((halt_go && !wdt_overflow) |=> pdf_q && !to_q && wdt_clear_q)
    else $error("halt did not update flags or clear watchdog");
  a_pdf_sticky: assert property ((pdf_q && !clr_wdt_exec) |=> pdf_q)
    else $error("power-down flag dropped without clear instruction");
  a_pin_wake: assert property ((st_q == PMC_HALT && (|pa_fall)) |=> st_q == PMC_RESTART)
    else $error("enabled pin falling edge did not wake");
  a_no_stale_wake: assert property ((st_q == PMC_HALT && !(|pa_fall) && !wdt_overflow && !(|irq_wake))
    |=> st_q == PMC_HALT)
    else $error("woke without an armed source");
  a_wdt_wake_to: assert property ((st_q == PMC_HALT && wdt_overflow) |=> to_q ##0 st_q == PMC_RESTART)
    else $error("watchdog wake did not set time-out flag");
  a_hs_settle: assert property ((hs_on_q && hs_cnt_q != 8'(HS_STABLE_CYC)) |=> !hs_stable_q)
    else $error("fast oscillator flagged stable too early");
  a_wake_waits: assert property ((st_q == PMC_RESTART && !src_ok)
    |=> !cpu_run_q ##0 !resume_q && !vector_q)
    else $error("core released before clock source stable");
  a_vector_rule: assert property ((leave_restart && !wake_wdt_q && wake_irq_q && irq_serviceable)
    |=> vector_q && !resume_q && cpu_run_q)
    else $error("serviceable interrupt wake did not vector");

  c_sleep_entry: cover property (halt_go && !hs_osc_halt_keep_q && !ls_osc_halt_keep_q);
  c_irq_vector: cover property (vector_q);
  c_pin_resume: cover property (st_q == PMC_HALT && (|pa_fall) ##[1:300] resume_q);
  c_slow_mode: cover property (mode_q == PMC_SLOW);

endmodule : pmc_top

/* File: hw/pmc_pkg.sv */
// Package of the operating-mode controller: register map, fields, resets, timing and types.
// Assumes a 125 MHz ref_clk and byte-wide registers on a plain strobe port.

package pmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SYSCLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_HS_OSC_CTRL = 4'h1;
  localparam logic [3:0] ADDR_WAKE_EN = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int HS_KEEP_BIT = 1;
  localparam int LS_KEEP_BIT = 0;
  localparam int HS_FLAG_BIT = 1;
  localparam int HS_EN_BIT = 0;
  localparam int PDF_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int SLOW_ACT_BIT = 2;
  localparam int MODE_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_RST = 3'h1;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic HS_EN_RST = 1'b1;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int HS_STABLE_NS = 1024;
  // Least time, so round up
  localparam int HS_STABLE_CYC = (HS_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PMC_FAST, PMC_SLOW, PMC_SLEEP, PMC_IDLE0, PMC_IDLE1, PMC_IDLE2} pmc_mode_type;
  typedef enum logic [1:0] {PMC_RUN, PMC_HALT, PMC_RESTART} pmc_state_type;
  typedef enum logic [1:0] {SW_IDLE, SW_CUR, SW_TAR} pmc_sw_state_type;

  // Halt mode from the two keep-alive bits
  function automatic pmc_mode_type pmc_halt_mode(input logic hs_keep, input logic ls_keep);
    pmc_mode_type m;
    m = PMC_SLEEP;
    if (hs_keep && ls_keep) begin
      m = PMC_IDLE1;
    end else if (hs_keep) begin
      m = PMC_IDLE2;
    end else if (ls_keep) begin
      m = PMC_IDLE0;
    end
    return m;
  endfunction : pmc_halt_mode

  // Divider mask: select code n from 0 to 6 gives a tick every 2**n cycles
  function automatic logic [5:0] pmc_div_mask(input logic [2:0] sel);
    logic [6:0] one_hot;
    one_hot = 7'h01 << sel;
    return 6'(one_hot - 7'h01);
  endfunction : pmc_div_mask

endpackage : pmc_pkg

/* File: hw/pmc_clk_switch.sv */
// Glitch-free selector between the undivided fast clock and the sub clock.
// Assumes both clocks arrive as one-cycle tick enables synchronous to ref_clk.
`timescale 1ns/100ps

module pmc_clk_switch
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request
  input wire logic target_slow,
  input wire logic hs_tick,
  input wire logic ls_tick,
  input wire logic hs_ok,
  input wire logic ls_ok,
  // Result
  output logic slow_active
);
  import pmc_pkg::*;

  pmc_sw_state_type st_q, st_d;
  logic slow_q, slow_d;
  logic cur_tick, tar_tick, tar_ok;

  assign cur_tick = slow_q ? ls_tick : hs_tick;
  assign tar_tick = slow_q ? hs_tick : ls_tick;
  assign tar_ok = target_slow ? ls_ok : hs_ok;
  assign slow_active = slow_q;

  // Target must be stable before leaving; then one edge of each clock
  always_comb begin
    st_d = st_q;
    slow_d = slow_q;
    unique case (st_q)
      SW_IDLE: if (target_slow != slow_q && tar_ok) st_d = SW_CUR;
      SW_CUR: if (cur_tick) st_d = SW_TAR;
      SW_TAR: begin
        if (tar_tick) begin
          st_d = SW_IDLE;
          slow_d = ~slow_q;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= SW_IDLE;
      slow_q <= 1'b0;
    end else begin
      st_q <= st_d;
      slow_q <= slow_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ls_gate_wait: assert property ((st_q == SW_IDLE && target_slow && !slow_q && !ls_ok)
    |=> st_q == SW_IDLE)
    else $error("switch to sub clock left idle before oscillator stable");
  a_switch_two_edges: assert property ($changed(slow_q)
    |-> $past(st_q) == SW_TAR && $past(tar_tick))
    else $error("clock source flipped outside a target clock tick");

endmodule : pmc_clk_switch

/* File: verif/pmc_core_model.sv */
// Core model: turns bench halt requests into one-cycle halt pulses and makes the sub clock ticks.
// Assumes the bench raises halt_req for one cycle, right after a rising edge.
`timescale 1ns/100ps

module pmc_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bench request and core state
  input wire logic halt_req,
  input wire logic cpu_run,
  // Towards the controller
  output logic halt_exec,
  output logic ls_tick
);
  logic [2:0] lsdiv_q;

  // A stopped core executes nothing, so a halt is only issued while running
  always @(posedge ref_clk) begin
    halt_exec <= halt_req & cpu_run & ~rst;
    lsdiv_q <= rst ? 3'h0 : lsdiv_q + 3'h1;
    ls_tick <= ~rst & (lsdiv_q == 3'h7);
  end
endmodule : pmc_core_model

/* File: verif/testbench.sv */
// Self-checking bench of the operating-mode controller: registers, clock switch, halt and wake.
// Assumes the core model file and a 125 MHz reference clock.
`timescale 1ns/100ps

module testbench;
  import pmc_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, halt_req, clr_wdt_exec, stack_full, wdt_overflow, ls_osc_stable;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, irq_req, irq_enable, porta_in;
  logic halt_exec, cpu_run, resume_pulse, vector_pulse, pc_sp_reset, wdt_clear, ls_tick, rd_d;
  logic hs_osc_on, sub_clk_on, sys_tick, power_down_flag, wdt_timeout_flag;
  logic [2:0] p;
  logic [31:0] seed;
  pmc_mode_type mode;
  pmc_mode_type modes [4] = '{PMC_SLEEP, PMC_IDLE0, PMC_IDLE2, PMC_IDLE1};
  int n_fail, samples_checked, cnt;
  logic [7:0] exp_q[$];
  logic [2:0] pulse_q[$];

  pmc_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
    .cpu_run(cpu_run), .resume_pulse(resume_pulse), .vector_pulse(vector_pulse), .pc_sp_reset(pc_sp_reset),
    .irq_req(irq_req), .irq_enable(irq_enable), .stack_full(stack_full), .porta_in(porta_in),
    .wdt_overflow(wdt_overflow), .wdt_clear(wdt_clear), .ls_osc_stable(ls_osc_stable), .ls_tick(ls_tick),
    .hs_osc_on(hs_osc_on), .sub_clk_on(sub_clk_on), .sys_tick(sys_tick), .mode(mode),
    .power_down_flag(power_down_flag), .wdt_timeout_flag(wdt_timeout_flag));
  pmc_core_model core_u (.ref_clk(ref_clk), .rst(rst), .halt_req(halt_req), .cpu_run(cpu_run),
    .halt_exec(halt_exec), .ls_tick(ls_tick));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ------
  // Tasks
  // ------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic ticks(input int n, input logic [7:0] e);
    cnt = 0;
    repeat (n) begin
      @(posedge ref_clk);
      cnt += int'(sys_tick === 1'b1);
    end
    check("sys_tick count", 8'(cnt), e);
  endtask : ticks

  task automatic halt(input pmc_mode_type em);
    @(posedge ref_clk);
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("mode", 8'(mode), 8'(em));
    check("halt flags", {4'h0, cpu_run, power_down_flag, wdt_timeout_flag, wdt_clear}, 8'h05);
  endtask : halt

  // Wake latency depends on oscillator restart, so the wait is bounded, not fixed
  task automatic wait_run(input int bound);
    cnt = 0;
    while (cpu_run !== 1'b1 && cnt < bound) begin
      @(posedge ref_clk);
      cnt++;
    end
    if (cpu_run !== 1'b1) begin
      check("cpu_run wake", {7'h0, cpu_run}, 8'h01);
      finish_test();
    end else begin
      repeat (2) @(posedge ref_clk);
    end
  endtask : wait_run

  always @(posedge ref_clk) begin
    if (rd_d) begin
      check("reg_rdata", reg_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    end
    rd_d <= reg_rd;
    if ({pc_sp_reset, vector_pulse, resume_pulse} !== 3'h0) begin
      check("wake pulse", {5'h0, pc_sp_reset, vector_pulse, resume_pulse},
        {5'h0, pulse_q.size() ? pulse_q.pop_front() : 3'h0});
    end
  end

  // ------
  // Scenarios
  // ------
  initial begin
    seed = 32'hdcf831c9;
    rst = 1'b1;
    {reg_wr, reg_rd, halt_req, clr_wdt_exec, stack_full, wdt_overflow, ls_osc_stable, rd_d} = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    irq_req = 8'h00;
    irq_enable = 8'hff;
    porta_in = 8'hff;
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_SYSCLK_CTRL, 8'h20);
    rd(ADDR_HS_OSC_CTRL, 8'h01);
    repeat (140) @(posedge ref_clk);
    wr(ADDR_HS_OSC_CTRL, 8'hfd);
    wr(ADDR_STATUS, 8'hff);
    wr(4'h9, 8'hff);
    rd(ADDR_HS_OSC_CTRL, 8'h03);
    rd(ADDR_STATUS, 8'h00);
    rd(4'h9, 8'h00);
    for (int n = 0; n < 7; n++) begin
      wr(ADDR_SYSCLK_CTRL, 8'(n << SEL_LSB));
      repeat (20) @(posedge ref_clk);
      ticks(128, 8'(128 >> n));
    end
    // Sub clock not yet stable: the switch must hang back
    wr(ADDR_SYSCLK_CTRL, 8'he0);
    repeat (40) @(posedge ref_clk);
    rd(ADDR_STATUS, 8'h00);
    ls_osc_stable <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd(ADDR_STATUS, 8'h14);
    ticks(64, 8'h08);
    wr(ADDR_HS_OSC_CTRL, 8'h00);
    wr(ADDR_SYSCLK_CTRL, 8'h00);
    wr(ADDR_HS_OSC_CTRL, 8'h01);
    repeat (50) @(posedge ref_clk);
    rd(ADDR_HS_OSC_CTRL, 8'h01);
    rd(ADDR_STATUS, 8'h14);
    repeat (150) @(posedge ref_clk);
    rd(ADDR_HS_OSC_CTRL, 8'h03);
    rd(ADDR_STATUS, 8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      p = seed[2:0];
      wr(ADDR_WAKE_EN, 8'h01 << p);
      wr(ADDR_SYSCLK_CTRL, 8'h20 | 8'(k));
      halt(modes[k]);
      repeat (5) @(posedge ref_clk);
      check("clocks", {6'h0, hs_osc_on, sub_clk_on}, 8'(k));
      porta_in <= ~(8'h01 << p);
      pulse_q.push_back(3'h1);
      wait_run(400);
      porta_in <= 8'hff;
      rd(ADDR_SYSCLK_CTRL, 8'h20 | 8'(k));
      rd(ADDR_STATUS, 8'h01);
    end
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      p = seed[2:0];
      irq_enable <= (k == 1) ? 8'h00 : 8'hff;
      stack_full <= (k == 2);
      halt(PMC_IDLE1);
      irq_req <= 8'h01 << p;
      pulse_q.push_back(k == 0 ? 3'h2 : 3'h1);
      wait_run(100);
      irq_req <= 8'h00;
    end
    irq_req <= 8'h80;
    stack_full <= 1'b0;
    wr(ADDR_WAKE_EN, 8'h01);
    wr(ADDR_SYSCLK_CTRL, 8'h22);
    halt(PMC_IDLE2);
    porta_in <= 8'hfd;
    repeat (30) @(posedge ref_clk);
    check("cpu_run", {7'h0, cpu_run}, 8'h00);
    wdt_overflow <= 1'b1;
    pulse_q.push_back(3'h4);
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    wait_run(100);
    rd(ADDR_STATUS, 8'h03);
    clr_wdt_exec <= 1'b1;
    @(posedge ref_clk);
    clr_wdt_exec <= 1'b0;
    @(posedge ref_clk);
    check("wdt_clear", {7'h0, wdt_clear}, 8'h01);
    @(posedge ref_clk);
    rd(ADDR_STATUS, 8'h02);
    repeat (4) @(posedge ref_clk);
    // Every noted read and wake pulse must have been seen
    check("notes left", 8'(exp_q.size() + pulse_q.size()), 8'h00);
    finish_test();
  end
endmodule : testbench
